// File: core/pmc_pkg.sv
// constants, field layouts and carrier types of the measurement setup
// and calibration register bank; shared by the bank and its bench.
// assumes a single 40 MHz clock and a plain strobe register port.
package pmc_pkg;

    // ------------------------------------------------------------------
    // bus geometry and register offsets
    // ------------------------------------------------------------------
    localparam int PMC_ADDR_W = 6;
    localparam int PMC_DATA_W = 16;
    localparam int PMC_GO_N = 14;
    localparam int PMC_PH_N = 3;
    localparam logic [5:0] PMC_SETUP_OFS = 6'h00;
    localparam logic [5:0] PMC_GO_REQ_OFS = 6'h01;
    localparam logic [5:0] PMC_GO_ECHO_OFS = 6'h02;
    localparam logic [5:0] PMC_ANG_REQ_OFS = 6'h03;
    localparam logic [5:0] PMC_ANG_ECHO_OFS = 6'h04;
    localparam logic [5:0] PMC_GO_SET_OFS = 6'h10;
    localparam logic [5:0] PMC_GO_RB_OFS = 6'h20;
    localparam logic [5:0] PMC_ANG_SET_OFS = 6'h30;
    localparam logic [5:0] PMC_ANG_RB_OFS = 6'h34;

    // ------------------------------------------------------------------
    // setup word fields
    // ------------------------------------------------------------------
    localparam int PMC_B_SUM_C = 0;
    localparam int PMC_B_SUM_B = 1;
    localparam int PMC_B_SUM_A = 2;
    localparam int PMC_B_ACT_ABS = 3;
    localparam int PMC_B_REA_ABS = 4;
    localparam int PMC_B_APP_VEC = 6;
    localparam int PMC_B_P2_REA = 7;
    localparam int PMC_B_3W = 8;
    localparam int PMC_B_INTEG = 10;
    localparam int PMC_B_HPF_OFF = 11;
    localparam int PMC_B_F60 = 12;
    localparam int PMC_B_SWAP = 13;
    localparam logic [15:0] PMC_SETUP_MASK = 16'h3fdf;
    localparam logic [15:0] PMC_SETUP_RST = 16'h0087;

    // ------------------------------------------------------------------
    // angle word fields, request codes, reset values
    // ------------------------------------------------------------------
    localparam int PMC_ANG_DLY_W = 10;
    localparam int PMC_ANG_VSEL = 15;
    localparam logic [15:0] PMC_ANG_MASK = 16'h83ff;
    localparam logic [15:0] PMC_ANG_RST = 16'h0000;
    localparam logic [15:0] PMC_REQ_RESET = 16'hffff;
    localparam logic [15:0] PMC_REQ_RST = 16'hffff;
    localparam logic [15:0] PMC_VGAIN_RST = 16'h6720;
    localparam logic [15:0] PMC_CGAIN_RST = 16'h4000;
    localparam logic [15:0] PMC_OFS_RST = 16'h0000;
    // order: voltage gain a..c, current gain a..n, voltage offset a..c,
    // current offset a..n
    localparam logic [13:0][15:0] PMC_GO_RST = {
        {7{PMC_OFS_RST}}, {4{PMC_CGAIN_RST}}, {3{PMC_VGAIN_RST}}};

    // ------------------------------------------------------------------
    // timing: delay base derived from the system clock
    // ------------------------------------------------------------------
    localparam int PMC_CLK_PERIOD_NS = 25;
    localparam int PMC_CLK_KHZ = 1000000 / PMC_CLK_PERIOD_NS;
    localparam int PMC_BASE_KHZ = 2048;
    localparam logic [15:0] PMC_ACC_RST = 16'h0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sum_en_a;
        logic sum_en_b;
        logic sum_en_c;
        logic active_abs;
        logic reactive_abs;
        logic apparent_vector;
        logic second_pulse_source;
        logic three_phase_three_wire;
        logic measure_b;
        logic seq_abc_check;
        logic seq_ac180_check;
        logic derivative_sensor;
        logic hpf_on;
        logic freq_60hz;
        logic input_swap;
    } pmc_cfg_s;

    typedef struct packed {
        logic to_voltage;
        logic [9:0] delay;
    } pmc_angle_s;

endpackage : pmc_pkg

// File: core/pmc_bank.sv
// setup and calibration register bank of the power measurement unit.
// assumes a bus master on the same clock, strobes one cycle long.
//
// The plain strobed port and the register offsets were decided locally.
module pmc_bank
    import pmc_pkg::*;
#(
    parameter int CLK_KHZ = PMC_CLK_KHZ
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // register port
    input wire logic [PMC_ADDR_W-1:0] ADDR,
    input wire logic [PMC_DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [PMC_DATA_W-1:0] RDATA,
    // configuration to the measurement path
    output pmc_cfg_s CFG,
    output logic [PMC_GO_N-1:0][15:0] GAIN_OFS,
    output pmc_angle_s [PMC_PH_N-1:0] ANGLE,
    output logic DELAY_TICK
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (CLK_KHZ < 2 * PMC_BASE_KHZ || CLK_KHZ > 65535)
    begin : g_bad_clk
        $error("clock rate cannot serve the delay base");
    end

    localparam logic [16:0] CLK_K = 17'(CLK_KHZ);
    localparam logic [16:0] BASE_K = 17'(PMC_BASE_KHZ);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] setup;
        pmc_cfg_s cfg;
        logic [PMC_GO_N-1:0][15:0] go_pend;
        logic [PMC_GO_N-1:0][15:0] go_act;
        logic [15:0] go_req;
        logic [15:0] go_echo;
        logic go_busy;
        logic [PMC_PH_N-1:0][15:0] ang_pend;
        logic [PMC_PH_N-1:0][15:0] ang_act;
        logic [15:0] ang_req;
        logic [15:0] ang_echo;
        logic ang_busy;
        logic [15:0] rdata;
        logic [15:0] acc;
        logic tick;
    } pmc_state_s;

    pmc_state_s s;
    pmc_state_s next_s;
    logic [5:0] go_set_idx;
    logic [5:0] go_rb_idx;
    logic [5:0] ang_set_idx;
    logic [5:0] ang_rb_idx;
    logic [16:0] acc_sum;

    assign go_set_idx = ADDR - PMC_GO_SET_OFS;
    assign go_rb_idx = ADDR - PMC_GO_RB_OFS;
    assign ang_set_idx = ADDR - PMC_ANG_SET_OFS;
    assign ang_rb_idx = ADDR - PMC_ANG_RB_OFS;
    assign acc_sum = {1'b0, s.acc} + BASE_K;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.rdata = 16'h0000;
        // echo first: a request written in the same cycle re-arms busy,
        // so back-to-back requests never lose the second echo
        if (s.go_busy)
        begin
            next_s.go_echo = s.go_req;
            next_s.go_busy = 1'b0;
        end
        if (s.ang_busy)
        begin
            next_s.ang_echo = s.ang_req;
            next_s.ang_busy = 1'b0;
        end
        // register writes
        if (WR)
        begin
            if (ADDR == PMC_SETUP_OFS)
            begin
                // reserved bits stay zero; bit 9 is kept as written
                next_s.setup = WDATA & PMC_SETUP_MASK;
            end
            else if (ADDR == PMC_GO_REQ_OFS)
            begin
                next_s.go_req = WDATA;
                next_s.go_busy = 1'b1;
                if (WDATA != PMC_REQ_RESET)
                begin
                    next_s.go_act = s.go_pend;
                end
            end
            else if (ADDR == PMC_ANG_REQ_OFS)
            begin
                next_s.ang_req = WDATA;
                next_s.ang_busy = 1'b1;
                if (WDATA != PMC_REQ_RESET)
                begin
                    next_s.ang_act = s.ang_pend;
                end
            end
            else if (ADDR >= PMC_GO_SET_OFS &&
                     go_set_idx < 6'(PMC_GO_N))
            begin
                // held until the next apply request
                next_s.go_pend[go_set_idx[3:0]] = WDATA;
            end
            else if (ADDR >= PMC_ANG_SET_OFS &&
                     ang_set_idx < 6'(PMC_PH_N))
            begin
                next_s.ang_pend[ang_set_idx[1:0]] =
                    WDATA & PMC_ANG_MASK;
            end
        end
        // register reads; write-only and unmapped words read zero
        if (RD)
        begin
            if (ADDR == PMC_SETUP_OFS)
            begin
                next_s.rdata = s.setup;
            end
            else if (ADDR == PMC_GO_REQ_OFS)
            begin
                next_s.rdata = s.go_req;
            end
            else if (ADDR == PMC_GO_ECHO_OFS)
            begin
                next_s.rdata = s.go_echo;
            end
            else if (ADDR == PMC_ANG_REQ_OFS)
            begin
                next_s.rdata = s.ang_req;
            end
            else if (ADDR == PMC_ANG_ECHO_OFS)
            begin
                next_s.rdata = s.ang_echo;
            end
            else if (ADDR >= PMC_GO_RB_OFS &&
                     go_rb_idx < 6'(PMC_GO_N))
            begin
                next_s.rdata = s.go_act[go_rb_idx[3:0]];
            end
            else if (ADDR >= PMC_ANG_RB_OFS &&
                     ang_rb_idx < 6'(PMC_PH_N))
            begin
                next_s.rdata = s.ang_act[ang_rb_idx[1:0]];
            end
        end
        // config decode from the new setup word
        next_s.cfg.sum_en_c = next_s.setup[PMC_B_SUM_C];
        next_s.cfg.sum_en_b = next_s.setup[PMC_B_SUM_B] &
            ~next_s.setup[PMC_B_3W];
        next_s.cfg.sum_en_a = next_s.setup[PMC_B_SUM_A];
        next_s.cfg.active_abs = next_s.setup[PMC_B_ACT_ABS];
        next_s.cfg.reactive_abs = next_s.setup[PMC_B_REA_ABS];
        next_s.cfg.apparent_vector = next_s.setup[PMC_B_APP_VEC];
        next_s.cfg.second_pulse_source =
            next_s.setup[PMC_B_P2_REA];
        next_s.cfg.three_phase_three_wire =
            next_s.setup[PMC_B_3W];
        next_s.cfg.measure_b = ~next_s.setup[PMC_B_3W];
        next_s.cfg.seq_abc_check = ~next_s.setup[PMC_B_3W];
        next_s.cfg.seq_ac180_check = next_s.setup[PMC_B_3W];
        next_s.cfg.derivative_sensor = next_s.setup[PMC_B_INTEG];
        next_s.cfg.hpf_on = ~next_s.setup[PMC_B_HPF_OFF];
        next_s.cfg.freq_60hz = next_s.setup[PMC_B_F60];
        next_s.cfg.input_swap = next_s.setup[PMC_B_SWAP];
        // fractional divider: average tick rate is the delay base,
        // jitter of one system clock is traded for a free-running clock
        next_s.tick = 1'b0;
        if (acc_sum >= CLK_K)
        begin
            next_s.acc = 16'(acc_sum - CLK_K);
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.acc = acc_sum[15:0];
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            s.setup <= PMC_SETUP_RST;
            s.cfg <= '{sum_en_a: 1'b1, sum_en_b: 1'b1, sum_en_c: 1'b1,
                       second_pulse_source: 1'b1, measure_b: 1'b1,
                       seq_abc_check: 1'b1, hpf_on: 1'b1,
                       default: 1'b0};
            s.go_pend <= PMC_GO_RST;
            s.go_act <= PMC_GO_RST;
            s.go_req <= PMC_REQ_RST;
            s.go_echo <= PMC_REQ_RST;
            s.go_busy <= 1'b0;
            s.ang_pend <= {PMC_PH_N{PMC_ANG_RST}};
            s.ang_act <= {PMC_PH_N{PMC_ANG_RST}};
            s.ang_req <= PMC_REQ_RST;
            s.ang_echo <= PMC_REQ_RST;
            s.ang_busy <= 1'b0;
            s.rdata <= 16'h0000;
            s.acc <= PMC_ACC_RST;
            s.tick <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign RDATA = s.rdata;
    assign CFG = s.cfg;
    assign GAIN_OFS = s.go_act;
    assign DELAY_TICK = s.tick;
    for (genvar p = 0; p < PMC_PH_N; p++)
    begin : g_ang
        assign ANGLE[p].to_voltage = s.ang_act[p][PMC_ANG_VSEL];
        assign ANGLE[p].delay =
            s.ang_act[p][PMC_ANG_DLY_W-1:0];
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    sequence s_setup_wr;
        WR && ADDR == PMC_SETUP_OFS;
    endsequence
    sequence s_go_apply;
        WR && ADDR == PMC_GO_REQ_OFS && WDATA != PMC_REQ_RESET;
    endsequence
    sequence s_go_reset;
        WR && ADDR == PMC_GO_REQ_OFS && WDATA == PMC_REQ_RESET;
    endsequence
    sequence s_go_set;
        WR && ADDR == PMC_GO_SET_OFS;
    endsequence

    property p_setup_sum;
        s_setup_wr |=> CFG.sum_en_a == $past(WDATA[PMC_B_SUM_A]) &&
            CFG.sum_en_c == $past(WDATA[PMC_B_SUM_C]) &&
            CFG.active_abs == $past(WDATA[PMC_B_ACT_ABS]) &&
            CFG.reactive_abs == $past(WDATA[PMC_B_REA_ABS]);
    endproperty
    a_setup_sum: assert property (p_setup_sum)
        else $error("sum controls do not follow setup write");

    property p_setup_modes;
        s_setup_wr |=> CFG.apparent_vector == $past(WDATA[6]) &&
            CFG.second_pulse_source == $past(WDATA[7]) &&
            CFG.derivative_sensor == $past(WDATA[10]) &&
            CFG.hpf_on != $past(WDATA[11]) &&
            CFG.freq_60hz == $past(WDATA[12]) &&
            CFG.input_swap == $past(WDATA[13]);
    endproperty
    a_setup_modes: assert property (p_setup_modes)
        else $error("mode controls do not follow setup write");

    property p_wiring;
        CFG.three_phase_three_wire == CFG.seq_ac180_check &&
            CFG.measure_b != CFG.three_phase_three_wire &&
            CFG.seq_abc_check == CFG.measure_b &&
            (CFG.three_phase_three_wire -> !CFG.sum_en_b);
    endproperty
    a_wiring: assert property (p_wiring)
        else $error("wiring decode inconsistent");

    property p_setup_reserved;
        RD && ADDR == PMC_SETUP_OFS |=>
            RDATA[15:14] == 2'b00 && RDATA[5] == 1'b0;
    endproperty
    a_setup_reserved: assert property (p_setup_reserved)
        else $error("reserved setup bits read nonzero");

    // a request right behind the setting may legally move the values
    property p_go_hold;
        s_go_set |=> $stable(GAIN_OFS) and
            (!(WR && ADDR == PMC_GO_REQ_OFS) |=> $stable(GAIN_OFS));
    endproperty
    a_go_hold: assert property (p_go_hold)
        else $error("gain setting took effect without request");

    property p_go_apply;
        s_go_apply ##1 !(WR && ADDR == PMC_GO_REQ_OFS) |->
            ##1 s.go_echo == $past(WDATA, 2) &&
            GAIN_OFS == $past(s.go_pend, 2);
    endproperty
    a_go_apply: assert property (p_go_apply)
        else $error("apply echo or values wrong");

    property p_go_reset;
        s_go_reset |=> $stable(GAIN_OFS) ##1 s.go_echo == PMC_REQ_RESET;
    endproperty
    a_go_reset: assert property (p_go_reset)
        else $error("reset request applied values");

    property p_ang_hold;
        WR && ADDR == PMC_ANG_SET_OFS |=> $stable(ANGLE);
    endproperty
    a_ang_hold: assert property (p_ang_hold)
        else $error("angle setting took effect without request");

    property p_ang_rb;
        RD && ADDR == PMC_ANG_RB_OFS |=>
            RDATA == $past(s.ang_act[0]) && RDATA[14:10] == 5'h00;
    endproperty
    a_ang_rb: assert property (p_ang_rb)
        else $error("angle readback not the active value");

    property p_tick;
        DELAY_TICK |=> !DELAY_TICK [*8];
    endproperty
    a_tick: assert property (p_tick)
        else $error("delay base ticks too close");

    sequence s_ang_apply;
        WR && ADDR == PMC_ANG_REQ_OFS && WDATA != PMC_REQ_RESET;
    endsequence
    sequence s_ang_reset;
        WR && ADDR == PMC_ANG_REQ_OFS && WDATA == PMC_REQ_RESET;
    endsequence

    // a second request right behind the first must not hide its echo
    property p_ang_apply;
        s_ang_apply |=> s.ang_act == $past(s.ang_pend) ##1
            s.ang_echo == $past(WDATA, 2);
    endproperty
    a_ang_apply: assert property (p_ang_apply)
        else $error("angle apply values or echo wrong");

    property p_ang_reset;
        s_ang_reset |=> $stable(ANGLE);
    endproperty
    a_ang_reset: assert property (p_ang_reset)
        else $error("angle reset request applied values");

    property p_go_echo_hold;
        !(WR && ADDR == PMC_GO_REQ_OFS) && !s.go_busy |=>
            $stable(s.go_echo);
    endproperty
    a_go_echo_hold: assert property (p_go_echo_hold)
        else $error("gain echo moved without a request");

    property p_setup_hold;
        !(WR && ADDR == PMC_SETUP_OFS) |=> $stable(CFG);
    endproperty
    a_setup_hold: assert property (p_setup_hold)
        else $error("setup decode moved without a write");

    property p_ang_reserved;
        ((s.ang_pend[0] | s.ang_pend[1] | s.ang_pend[2]) &
            ~PMC_ANG_MASK) == 16'h0000;
    endproperty
    a_ang_reserved: assert property (p_ang_reserved)
        else $error("reserved angle bits stored");

endmodule : pmc_bank

// File: tb/pmc_ctrl_model.sv
// bus controller model for the setup and calibration bank.
// assumes the bank answers a read in the cycle after the strobe.
module pmc_ctrl_model
    import pmc_pkg::*;
(
    // clock
    input wire logic clk,
    // register port toward the bank
    input wire logic [PMC_DATA_W-1:0] rdata,
    output logic [PMC_ADDR_W-1:0] addr,
    output logic [PMC_DATA_W-1:0] wdata,
    output logic wr_stb,
    output logic rd_stb
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        addr = 6'h00;
        wdata = 16'h0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    // ------------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------------
    // idle address and data are inverted so a stale sample shows up
    task automatic bus_wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask : bus_wr

    task automatic bus_rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : bus_rd

    // ------------------------------------------------------------------
    // controller procedures
    // ------------------------------------------------------------------
    task automatic wr_setup(input logic [15:0] d);
        bus_wr(PMC_SETUP_OFS, d & 16'hfdff);
    endtask : wr_setup

    task automatic apply(input logic [5:0] req, input logic [5:0] echo,
        input logic [15:0] code, output logic ok);
        logic [15:0] d;
        bus_wr(req, code);
        ok = 1'b0;
        // bounded poll: a stuck echo must not hang the controller
        for (int n = 0; n < 8 && !ok; n++)
        begin
            bus_rd(echo, d);
            ok = (d === code);
        end
    endtask : apply

    // called at startup and again after every reset of the bank
    task automatic angle_load(input logic [15:0] a, input logic [15:0] b,
        input logic [15:0] c, output logic ok);
        logic ok1;
        apply(PMC_ANG_REQ_OFS, PMC_ANG_ECHO_OFS, 16'hffff, ok1);
        bus_wr(PMC_ANG_SET_OFS, a);
        bus_wr(PMC_ANG_SET_OFS + 6'h01, b);
        bus_wr(PMC_ANG_SET_OFS + 6'h02, c);
        apply(PMC_ANG_REQ_OFS, PMC_ANG_ECHO_OFS, 16'h0001, ok);
        ok = ok & ok1;
    endtask : angle_load

endmodule : pmc_ctrl_model

// File: tb/tb_pmc_bank.sv
// self-checking bench of the setup and calibration bank.
// assumes the controller model above drives the register port.
module tb_pmc_bank
    import pmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    pmc_cfg_s cfg;
    logic [PMC_GO_N-1:0][15:0] gain_ofs;
    pmc_angle_s [PMC_PH_N-1:0] angle;
    logic delay_tick;
    int failures = 0;
    int tests_run = 0;

    always #12.5 clk = ~clk;

    pmc_bank #(.CLK_KHZ(PMC_CLK_KHZ)) i_pmc_bank (.CLK(clk), .NRST(nrst),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CFG(cfg), .GAIN_OFS(gain_ofs), .ANGLE(angle),
        .DELAY_TICK(delay_tick));

    pmc_ctrl_model i_pmc_ctrl_model (.clk(clk), .rdata(rdata),
        .addr(addr), .wdata(wdata), .wr_stb(wr), .rd_stb(rd));

    // ------------------------------------------------------------------
    // compares and expectations
    // ------------------------------------------------------------------
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk_cfg(input pmc_cfg_s got, input pmc_cfg_s exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: cfg %h expected %h", $time, got, exp);
        end
    endtask : chk_cfg

    task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_pmc_ctrl_model.bus_rd(a, d);
        chk16(d, exp);
    endtask : rdchk

    // three-wire drops phase b from the sum whatever bit 1 says
    function automatic pmc_cfg_s exp_cfg(input logic [15:0] w);
        return {w[2], w[1] & ~w[8], w[0], w[3], w[4], w[6], w[7], w[8],
            ~w[8], ~w[8], w[8], w[10], ~w[11], w[12], w[13]};
    endfunction : exp_cfg

    function automatic logic [15:0] go_val(input int i);
        return (i < 7) ? 16'h5000 + 16'(i) : 16'(-i);
    endfunction : go_val

    function automatic logic [15:0] go_rst(input int i);
        return (i < 3) ? 16'h6720 : (i < 7) ? PMC_CGAIN_RST : 16'h0000;
    endfunction : go_rst

    function automatic logic [15:0] ang_word(input pmc_angle_s a);
        return {a.to_voltage, 5'h00, a.delay};
    endfunction : ang_word

    task automatic check_go(input logic fresh);
        logic [15:0] e;
        for (int i = 0; i < PMC_GO_N; i++)
        begin
            e = fresh ? go_val(i) : go_rst(i);
            chk16(gain_ofs[i], e);
            rdchk(PMC_GO_RB_OFS + 6'(i), e);
        end
    endtask : check_go

    task automatic check_ang(input logic [2:0][15:0] e);
        for (int i = 0; i < PMC_PH_N; i++)
        begin
            chk16(ang_word(angle[i]), e[i]);
            rdchk(PMC_ANG_RB_OFS + 6'(i), e[i]);
        end
    endtask : check_ang

    task automatic do_reset;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk16({15'h0000, delay_tick}, 16'h0000);
        @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk_cfg(cfg, exp_cfg(16'h0087));
        rdchk(PMC_SETUP_OFS, 16'h0087);
        rdchk(PMC_GO_ECHO_OFS, 16'hffff);
        rdchk(PMC_ANG_ECHO_OFS, 16'hffff);
        check_go(1'b0);
        check_ang({3{16'h0000}});
    endtask : do_reset

    task automatic print_verdict;
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        logic [15:0] w;
        logic ok;
        int cyc;
        int seen;
        do_reset();
        // each setup bit alone except the resolution bit, then every bit but the resolution bit
        for (int i = 0; i < 17; i++)
        begin
            if (i == 9)
                continue;
            w = (i == 16) ? 16'hfdff : 16'h0001 << i;
            i_pmc_ctrl_model.wr_setup(w);
            chk_cfg(cfg, exp_cfg(w));
            rdchk(PMC_SETUP_OFS, w & 16'h3fdf);
        end
        @(posedge clk);
        #1;
        chk16(rdata, 16'h0000);
        i_pmc_ctrl_model.bus_wr(6'h3f, 16'h1111);
        rdchk(6'h3f, 16'h0000);
        rdchk(PMC_SETUP_OFS, 16'h3ddf);
        // gain and offset settings wait for a real request
        for (int i = 0; i < PMC_GO_N; i++)
            i_pmc_ctrl_model.bus_wr(PMC_GO_SET_OFS + 6'(i), go_val(i));
        rdchk(PMC_GO_SET_OFS, 16'h0000);
        check_go(1'b0);
        i_pmc_ctrl_model.apply(PMC_GO_REQ_OFS, PMC_GO_ECHO_OFS, 16'hffff, ok);
        chk16({15'h0000, ok}, 16'h0001);
        check_go(1'b0);
        i_pmc_ctrl_model.apply(PMC_GO_REQ_OFS, PMC_GO_ECHO_OFS, 16'h0005, ok);
        chk16({15'h0000, ok}, 16'h0001);
        check_go(1'b1);
        i_pmc_ctrl_model.bus_wr(PMC_GO_SET_OFS, 16'h1234);
        chk16(gain_ofs[0], go_val(0));
        // angle corrections
        i_pmc_ctrl_model.bus_wr(PMC_ANG_SET_OFS, 16'h8155);
        check_ang({3{16'h0000}});
        i_pmc_ctrl_model.angle_load(16'hffff, 16'h7c01, 16'h03ff, ok);
        chk16({15'h0000, ok}, 16'h0001);
        check_ang({16'h03ff, 16'h0001, 16'h83ff});
        i_pmc_ctrl_model.bus_wr(PMC_ANG_SET_OFS + 6'h01, 16'h0200);
        i_pmc_ctrl_model.apply(PMC_ANG_REQ_OFS, PMC_ANG_ECHO_OFS, 16'hffff, ok);
        check_ang({16'h03ff, 16'h0001, 16'h83ff});
        // 64 base periods span a whole number of system cycles
        for (int n = 0; n < 40 && delay_tick !== 1'b1; n++)
            @(posedge clk) #1;
        cyc = 0;
        seen = 0;
        while (seen < 64 && cyc < 2000)
        begin
            @(posedge clk);
            #1;
            cyc++;
            if (delay_tick === 1'b1)
                seen++;
        end
        chk16(16'(cyc), 16'(64 * 40000 / 2048));
        // a second reset loses the angles; the controller reloads them
        do_reset();
        i_pmc_ctrl_model.angle_load(16'h8001, 16'h0002, 16'h0003, ok);
        chk16({15'h0000, ok}, 16'h0001);
        check_ang({16'h0003, 16'h0002, 16'h8001});
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("ERROR %0t: run did not finish", $time);
        print_verdict();
    end

endmodule : tb_pmc_bank
